/* File: rtl/uart_line_status_defines.vh */
// register offsets, field positions and sizes for the line status block
`ifndef UART_LINE_STATUS_DEFINES_VH
`define UART_LINE_STATUS_DEFINES_VH

// ----------------------------------------
// apb register byte offsets
// ----------------------------------------
`define OFS_LINE_STATUS 12'h000
`define OFS_RX_DATA 12'h004
`define OFS_TX_DATA 12'h008
`define OFS_CONTROL 12'h00c
`define OFS_IRQ_STATUS 12'h010
`define OFS_IRQ_MASK 12'h014

// ----------------------------------------
// line_status fields
// ----------------------------------------
`define LS_DATA_READY 0
`define LS_OVERRUN 1
`define LS_PARITY_ERR 2
`define LS_FRAMING_ERR 3
`define LS_BREAK 4
`define LS_HOLDING_EMPTY 5
`define LS_TX_EMPTY 6
`define LS_FIFO_ERROR 7

// ----------------------------------------
// control fields and reset value
// ----------------------------------------
`define CTL_FIFO_ENABLE 0
`define CTL_HOLDING_IRQ_ENABLE 1
`define CTL_RESET 2'h0

// ----------------------------------------
// irq_status / irq_mask fields
// ----------------------------------------
`define IRQ_DATA_READY 0
`define IRQ_LINE_ERROR 1
`define IRQ_HOLDING_EMPTY 2
`define IRQ_BREAK 3
`define IRQ_WIDTH 4
`define IRQ_RESET 4'h0

// ----------------------------------------
// receive fifo geometry
// ----------------------------------------
`define RX_DEPTH 16
`define RX_PTR_W 4
`define RX_CNT_W 5
`define RX_DEPTH_CNT 5'h10
`define RX_ENTRY_W 11

`endif

/* File: rtl/rx_status_fifo.v */
// receive fifo holding each character with its parity, framing and break marks
`timescale 1ns/1ps
`default_nettype none
`include "uart_line_status_defines.vh"

module rx_status_fifo (
  input wire sys_clk,
  input wire rst_n,
  input wire fifo_en,
  input wire push,
  input wire [7:0] push_data,
  input wire push_perr,
  input wire push_ferr,
  input wire push_brk,
  input wire pop,
  output wire [7:0] head_data,
  output wire head_perr,
  output wire head_ferr,
  output wire head_brk,
  output wire data_ready,
  output wire err_any,
  output reg overrun
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // entry layout: [10] break, [9] framing, [8] parity, [7:0] data
  reg [`RX_ENTRY_W-1:0] mem [0:`RX_DEPTH-1];
  reg [`RX_PTR_W-1:0] wptr;
  reg [`RX_PTR_W-1:0] rptr;
  reg [`RX_CNT_W-1:0] count;
  reg [`RX_CNT_W-1:0] err_count;
  wire [`RX_CNT_W-1:0] limit;
  wire full;
  wire do_pop;
  wire do_push;
  wire [`RX_ENTRY_W-1:0] head;
  wire [`RX_ENTRY_W-1:0] new_entry;
  wire in_err;
  wire out_err;

  function has_error;
    input [`RX_ENTRY_W-1:0] e;
    begin
      has_error = e[8] | e[9] | e[10];
    end
  endfunction

  // without fifos only a single holding slot is in use
  // depth held at the counter's own width, so no bits are dropped here
  assign limit = fifo_en ? `RX_DEPTH_CNT : 5'h01;
  assign full = (count >= limit);
  assign do_pop = pop && (count != 5'h00);
  // a full fifo drops the new character, existing entries stay intact
  assign do_push = push && (!full || do_pop);
  assign head = mem[rptr];
  assign new_entry = {push_brk, push_ferr, push_perr, push_data};
  assign in_err = do_push && has_error(new_entry);
  assign out_err = do_pop && has_error(head);

  assign head_data = head[7:0];
  // flags follow the character at the read end
  assign head_perr = (count != 5'd0) && head[8];
  assign head_ferr = (count != 5'd0) && head[9];
  assign head_brk = (count != 5'd0) && head[10];
  assign data_ready = (count != 5'd0);
  assign err_any = (err_count != 5'd0);

  // ----------------------------------------
  // pointers and counts
  // ----------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= 4'h0;
      rptr <= 4'h0;
      count <= 5'h00;
      err_count <= 5'h00;
      overrun <= 1'b0;
    end else begin
      overrun <= push && !do_push;
      if (do_push) begin
        wptr <= wptr + 4'h1;
      end
      if (do_pop) begin
        rptr <= rptr + 4'h1;
      end
      count <= count + {4'h0, do_push} - {4'h0, do_pop};
      err_count <= err_count + {4'h0, in_err} - {4'h0, out_err};
    end
  end

  always @(posedge sys_clk) begin
    if (do_push) begin
      mem[wptr] <= new_entry;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/uart_line_status.v */
// line status flags, receive error fifo and apb register slave for one channel
// Function
// - fifo error bit 7 set while any fifo character has parity, framing or break
// - bit 7 clears only once no remaining fifo character carries an error
// - without fifo, bit 6 set when holding and shift register both empty
// - bit 6 low while holding or shift register still holds a character
// - with fifo, bit 6 set only when tx fifo and shift register empty
// - without fifo, bit 5 set when character moves from holding to shift
// - bit 5 clears in the cycle after the host writes the holding register
// - interrupt while holding-empty flag and its interrupt enable are both set
// - with fifo, bit 5 set on tx fifo empty, cleared on any write
// - break bit 4 set when line stays low for a whole frame
// - one continuous break loads only one break character into the fifo
// - framing bit 3 set when a character lacks a valid stop bit
// - with fifo, framing bit reports the character at the read end
// - break, framing and fifo error bits read zero after reset
// - parity bit 2 set for bad parity, tied to the read-end character
// - overrun bit 1 set when a character completes into a full fifo
// - data ready bit 0 set while any received character remains
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "uart_line_status_defines.vh"

module uart_line_status (
  input wire sys_clk,
  input wire arst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // serial receive pin and receiver datapath
  input wire rx_serial,
  input wire rx_bit_tick,
  input wire [3:0] frame_bits,
  input wire rx_char_valid,
  input wire [7:0] rx_char_data,
  input wire rx_char_parity_err,
  input wire rx_char_stop_bad,
  // transmit datapath
  input wire tx_load_shift,
  input wire tx_shift_empty,
  input wire tx_fifo_empty,
  output reg tx_write,
  output reg [7:0] tx_write_data,
  output wire fifo_enable,
  // interrupt
  output wire irq
);

  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  reg rst_meta;
  reg rst_n;
  reg rx_meta;
  reg rx_line;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // idle line is high, so the sync chain resets to one
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta <= 1'b1;
      rx_line <= 1'b1;
    end else begin
      rx_meta <= rx_serial;
      rx_line <= rx_meta;
    end
  end

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire setup_ph;
  wire access_ph;
  wire wr_acc;
  wire rd_acc;
  wire sel_ls;
  wire sel_rxd;
  wire sel_txd;
  wire sel_ctl;
  wire sel_ist;
  wire sel_imk;
  wire mapped;

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_acc = access_ph && pwrite;
  assign rd_acc = access_ph && !pwrite;
  assign sel_ls = (paddr == `OFS_LINE_STATUS);
  assign sel_rxd = (paddr == `OFS_RX_DATA);
  assign sel_txd = (paddr == `OFS_TX_DATA);
  assign sel_ctl = (paddr == `OFS_CONTROL);
  assign sel_ist = (paddr == `OFS_IRQ_STATUS);
  assign sel_imk = (paddr == `OFS_IRQ_MASK);
  assign mapped = sel_ls | sel_rxd | sel_txd | sel_ctl | sel_ist | sel_imk;

  // read data is captured in setup, so the access phase never waits
  assign pready = 1'b1;
  assign pslverr = access_ph && !mapped;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  reg [1:0] control;
  wire holding_irq_en;

  assign fifo_enable = control[`CTL_FIFO_ENABLE];
  assign holding_irq_en = control[`CTL_HOLDING_IRQ_ENABLE];

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      control <= `CTL_RESET;
    end else if (wr_acc && sel_ctl) begin
      control <= pwdata[1:0];
    end
  end

  // ----------------------------------------
  // break detection
  // ----------------------------------------
  reg [3:0] low_bits;
  reg break_held;
  wire break_event;

  // one event per continuous low stretch; rearmed only by a high line
  assign break_event = rx_bit_tick && !rx_line && !break_held &&
                       (low_bits + 4'h1 >= frame_bits);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_bits <= 4'h0;
      break_held <= 1'b0;
    end else begin
      if (rx_line) begin
        low_bits <= 4'h0;
        break_held <= 1'b0;
      end else if (rx_bit_tick) begin
        if (low_bits != 4'hf) begin
          low_bits <= low_bits + 4'h1;
        end
        if (break_event) begin
          break_held <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // receive fifo
  // ----------------------------------------
  wire rx_push;
  wire [7:0] push_data;
  wire push_perr;
  wire push_ferr;
  wire rx_pop;
  wire [7:0] head_data;
  wire head_perr;
  wire head_ferr;
  wire head_brk;
  wire data_ready;
  wire err_any;
  wire overrun_ev;

  // a break frame replaces the character the receiver reports for it
  assign rx_push = rx_char_valid || break_event;
  assign push_data = break_event ? 8'h00 : rx_char_data;
  assign push_perr = !break_event && rx_char_parity_err;
  assign push_ferr = !break_event && rx_char_stop_bad;
  assign rx_pop = rd_acc && sel_rxd;

  rx_status_fifo u_rx_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .fifo_en(fifo_enable),
    .push(rx_push),
    .push_data(push_data),
    .push_perr(push_perr),
    .push_ferr(push_ferr),
    .push_brk(break_event),
    .pop(rx_pop),
    .head_data(head_data),
    .head_perr(head_perr),
    .head_ferr(head_ferr),
    .head_brk(head_brk),
    .data_ready(data_ready),
    .err_any(err_any),
    .overrun(overrun_ev)
  );

  // ----------------------------------------
  // sticky break and overrun flags
  // ----------------------------------------
  reg break_flag;
  reg overrun_flag;
  reg [31:0] captured;
  wire ls_read;

  assign ls_read = rd_acc && sel_ls;

  // only bits already seen by the reader are cleared; new events win
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      break_flag <= 1'b0;
      overrun_flag <= 1'b0;
    end else begin
      break_flag <= (break_flag && !(ls_read && captured[`LS_BREAK])) ||
                    break_event;
      overrun_flag <= (overrun_flag && !(ls_read && captured[`LS_OVERRUN])) ||
                      overrun_ev;
    end
  end

  // ----------------------------------------
  // transmit holding and empty flags
  // ----------------------------------------
  reg holding_empty_nf;
  wire host_tx_write;
  wire holding_empty;
  wire tx_empty;

  assign host_tx_write = wr_acc && sel_txd;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      holding_empty_nf <= 1'b1;
      tx_write <= 1'b0;
      tx_write_data <= 8'h00;
    end else begin
      tx_write <= host_tx_write;
      if (host_tx_write) begin
        tx_write_data <= pwdata[7:0];
      end
      if (tx_load_shift) begin
        holding_empty_nf <= 1'b1;
      end else if (host_tx_write) begin
        holding_empty_nf <= 1'b0;
      end
    end
  end

  // a write in progress already counts as a filled fifo
  assign holding_empty = fifo_enable ? (tx_fifo_empty && !tx_write) :
                         holding_empty_nf;
  assign tx_empty = holding_empty && tx_shift_empty;

  // ----------------------------------------
  // line status value
  // ----------------------------------------
  wire [7:0] line_status;

  assign line_status = {err_any, tx_empty, holding_empty, break_flag,
                        head_ferr, head_perr, overrun_flag, data_ready};

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  reg [`IRQ_WIDTH-1:0] irq_status;
  reg [`IRQ_WIDTH-1:0] irq_mask;
  reg holding_empty_d;
  wire [`IRQ_WIDTH-1:0] irq_events;
  wire [`IRQ_WIDTH-1:0] irq_clear;

  assign irq_events[`IRQ_DATA_READY] = rx_push;
  assign irq_events[`IRQ_LINE_ERROR] = overrun_ev ||
                                       (rx_char_valid && (rx_char_parity_err ||
                                        rx_char_stop_bad));
  assign irq_events[`IRQ_HOLDING_EMPTY] = holding_empty && !holding_empty_d;
  assign irq_events[`IRQ_BREAK] = break_event;
  assign irq_clear = (wr_acc && sel_ist) ? pwdata[`IRQ_WIDTH-1:0] : `IRQ_RESET;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= `IRQ_RESET;
      irq_mask <= `IRQ_RESET;
      holding_empty_d <= 1'b1;
    end else begin
      holding_empty_d <= holding_empty;
      irq_status <= (irq_status & ~irq_clear) | irq_events;
      if (wr_acc && sel_imk) begin
        irq_mask <= pwdata[`IRQ_WIDTH-1:0];
      end
    end
  end

  assign irq = (|(irq_status & irq_mask)) ||
               (holding_empty && holding_irq_en);

  // ----------------------------------------
  // read data capture
  // ----------------------------------------
  reg [31:0] next_prdata;

  always @* begin
    next_prdata = 32'h0000_0000;
    case (1'b1)
      sel_ls: next_prdata = {24'h000000, line_status};
      sel_rxd: next_prdata = {21'h000000, head_brk, head_ferr, head_perr, head_data};
      sel_ctl: next_prdata = {30'h00000000, control};
      sel_ist: next_prdata = {28'h0000000, irq_status};
      sel_imk: next_prdata = {28'h0000000, irq_mask};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      captured <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= next_prdata;
      captured <= next_prdata;
    end
  end

endmodule
`default_nettype wire

/* File: tb/tx_line_model.sv */
// serial side stand-in: transmit shifter and receive bit tick source
`timescale 1ns/1ps
`default_nettype none
module tx_line_model #(parameter int SHIFT = 20, parameter int TICK = 4) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tx_write,
  output var logic tx_load_shift,
  output var logic rx_bit_tick,
  output wire logic tx_shift_empty,
  output wire logic tx_fifo_empty
);
  int busy;
  int tc;
  logic pend;
  assign tx_shift_empty = busy == 0;
  assign tx_fifo_empty = !pend;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 0;
      tc <= 0;
      pend <= 1'h0;
      tx_load_shift <= 1'h0;
      rx_bit_tick <= 1'h0;
    end else begin
      tc <= tc == TICK - 1 ? 0 : tc + 1;
      rx_bit_tick <= tc == TICK - 1;
      tx_load_shift <= pend && busy == 0;
      // a long SHIFT keeps the shift stage busy for a while
      if (pend && busy == 0) begin
        busy <= SHIFT;
        pend <= tx_write;
      end else begin
        busy <= busy == 0 ? 0 : busy - 1;
        pend <= pend || tx_write;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/uart_line_status_monitor.sv */
// port assertions for the line status block
`timescale 1ns/1ps
`default_nettype none
`include "uart_line_status_defines.vh"
module uart_line_status_monitor (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic tx_shift_empty,
  input wire logic tx_write,
  input wire logic [7:0] tx_write_data,
  input wire logic fifo_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire acc = psel && penable;
  wire rd_setup = psel && !penable && !pwrite;
  wire rd_ls = rd_setup && paddr == `OFS_LINE_STATUS;
  wire wr_tx = acc && pwrite && paddr == `OFS_TX_DATA;
  // ---
  // status snapshot is taken at the read setup edge
  // ---
  a_empty_order: assert property (rd_ls |=> !prdata[6] || prdata[5])
    else $error("tx empty while holding full");
  a_shift_busy: assert property (rd_ls && !tx_shift_empty |=> !prdata[6])
    else $error("tx empty while shifting");
  a_err_summary: assert property (rd_ls ##1 (prdata[2] || prdata[3]) |-> prdata[7])
    else $error("head error without summary");
  a_tx_pulse: assert property (wr_tx |=> tx_write && tx_write_data == $past(pwdata[7:0]))
    else $error("holding write not passed on");
  a_tx_cause: assert property (tx_write |-> $past(wr_tx))
    else $error("tx write without host write");
  a_txdata_hold: assert property ($changed(tx_write_data) |-> tx_write)
    else $error("tx data moved alone");
  a_mode_bit: assert property (acc && pwrite && paddr == `OFS_CONTROL
    |=> fifo_enable == $past(pwdata[0]))
    else $error("fifo mode not taken");
  a_read_hold: assert property (!rd_setup |=> $stable(prdata))
    else $error("read data moved");
  c_break_seen: cover property (rd_ls ##1 prdata[4]);
  c_overrun_seen: cover property (rd_ls ##1 prdata[1]);
  c_tx_write: cover property (wr_tx);
endmodule
bind uart_line_status uart_line_status_monitor mon (.sys_clk, .arst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .tx_shift_empty, .tx_write, .tx_write_data,
  .fifo_enable);
`default_nettype wire

/* File: tb/uart_line_status_tb_top.sv */
// self-checking bench for the line status block
`timescale 1ns/1ps
`default_nettype none
`include "uart_line_status_defines.vh"
module uart_line_status_tb_top;
  localparam logic [11:0] ls_a = `OFS_LINE_STATUS;
  localparam logic [11:0] rx_a = `OFS_RX_DATA;
  typedef struct {logic [7:0] d; logic p; logic f; logic [7:0] ls;} row_t;
  row_t rows [4] = '{'{8'h5a, 1'h0, 1'h0, 8'h61}, '{8'ha5, 1'h1, 1'h0, 8'he5},
    '{8'h3c, 1'h0, 1'h1, 8'he9}, '{8'hff, 1'h1, 1'h1, 8'hed}};
  logic sys_clk = 1'h0, arst_n = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic rx_serial = 1'h1, rx_char_valid = 1'h0;
  logic rx_char_parity_err = 1'h0, rx_char_stop_bad = 1'h0;
  logic [3:0] frame_bits = 4'ha;
  logic [7:0] rx_char_data = 8'h0;
  logic [31:0] prdata, rd;
  logic [7:0] tx_write_data;
  logic pready, pslverr, tx_write, fifo_enable, irq, err;
  logic tx_load_shift, tx_shift_empty, tx_fifo_empty, rx_bit_tick;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  uart_line_status uut (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .rx_serial, .rx_bit_tick, .frame_bits, .rx_char_valid,
    .rx_char_data, .rx_char_parity_err, .rx_char_stop_bad, .tx_load_shift,
    .tx_shift_empty, .tx_fifo_empty, .tx_write, .tx_write_data, .fifo_enable, .irq);
  tx_line_model far (.sys_clk, .rst_n(arst_n), .tx_write, .tx_load_shift,
    .rx_bit_tick, .tx_shift_empty, .tx_fifo_empty);
  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      results();
    end
  end
  // ---
  // tasks
  // ---
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  // edge wait first, so back-to-back calls never move psel twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
      input string n);
    apb(1'h0, a, 32'h0);
    chk(n, e, rd & m);
  endtask
  task automatic push(input logic [7:0] d, input logic p, input logic f);
    @(posedge sys_clk);
    rx_char_valid <= 1'h1;
    rx_char_data <= d;
    rx_char_parity_err <= p;
    rx_char_stop_bad <= f;
    @(posedge sys_clk);
    rx_char_valid <= 1'h0;
  endtask
  // waits for the shift load (0) or for an idle shifter (1); a lapse is a mismatch
  task automatic wt(input bit shift_done);
    int n;
    n = 0;
    while ((shift_done ? tx_shift_empty : tx_load_shift) !== 1'h1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 200) begin
      miscompares++;
      $display("BAD wait exp 1 seen 0");
    end
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge sys_clk);
    rdc(ls_a, 32'hff, 32'h60, "ls reset");
    apb(1'h0, 12'h020, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    chk("unmapped", 32'h0, rd);
    foreach (rows[i]) begin
      push(rows[i].d, rows[i].p, rows[i].f);
      rdc(ls_a, 32'hff, 32'(rows[i].ls), "ls char");
      rdc(rx_a, 32'h7ff, 32'({rows[i].f, rows[i].p, rows[i].d}), "rx char");
      rdc(ls_a, 32'hff, 32'h60, "ls popped");
    end
    rdc(`OFS_IRQ_STATUS, 32'h1, 32'h1, "irq status");
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'h1, `OFS_IRQ_MASK, 32'h1);
    #1 chk("irq on", 32'h1, 32'(irq));
    apb(1'h1, `OFS_IRQ_STATUS, 32'h1);
    #1 chk("irq cleared", 32'h0, 32'(irq));
    apb(1'h1, `OFS_IRQ_MASK, 32'h0);
    push(8'h11, 1'h0, 1'h0);
    push(8'h22, 1'h0, 1'h0);
    repeat (2) @(posedge sys_clk);
    rdc(ls_a, 32'h03, 32'h03, "overrun");
    rdc(ls_a, 32'h02, 32'h00, "overrun read");
    rdc(rx_a, 32'h7ff, 32'h11, "kept char");
    apb(1'h1, `OFS_CONTROL, 32'h1);
    push(8'h01, 1'h0, 1'h0);
    push(8'h02, 1'h0, 1'h1);
    push(8'h03, 1'h1, 1'h0);
    rdc(ls_a, 32'h8d, 32'h81, "head clean");
    rdc(rx_a, 32'h7ff, 32'h001, "pop one");
    rdc(ls_a, 32'h8d, 32'h89, "head framing");
    rdc(rx_a, 32'h7ff, 32'h202, "pop two");
    rdc(ls_a, 32'h8d, 32'h85, "head parity");
    rdc(rx_a, 32'h7ff, 32'h103, "pop three");
    rdc(ls_a, 32'h8d, 32'h00, "fifo empty");
    // line held low for three frames: still one break entry only
    rx_serial <= 1'h0;
    repeat (20) @(posedge sys_clk);
    rdc(ls_a, 32'h10, 32'h00, "no early break");
    repeat (100) @(posedge sys_clk);
    rdc(ls_a, 32'h91, 32'h91, "break");
    rdc(ls_a, 32'h10, 32'h00, "break read");
    rdc(rx_a, 32'h7ff, 32'h400, "break char");
    rdc(ls_a, 32'h01, 32'h00, "one break");
    rx_serial <= 1'h1;
    apb(1'h1, `OFS_CONTROL, 32'h2);
    #1 chk("irq idle", 32'h1, 32'(irq));
    apb(1'h1, `OFS_TX_DATA, 32'h41);
    #1 chk("irq busy", 32'h0, 32'(irq));
    rdc(ls_a, 32'h60, 32'h00, "holding full");
    wt(1'b0);
    rdc(ls_a, 32'h60, 32'h20, "shifting");
    #1 chk("irq again", 32'h1, 32'(irq));
    wt(1'b1);
    rdc(ls_a, 32'h60, 32'h60, "tx idle");
    apb(1'h1, `OFS_CONTROL, 32'h1);
    apb(1'h1, `OFS_TX_DATA, 32'h42);
    rdc(ls_a, 32'h60, 32'h00, "fifo written");
    wt(1'b0);
    rdc(ls_a, 32'h60, 32'h20, "fifo shifting");
    wt(1'b1);
    rdc(ls_a, 32'h60, 32'h60, "fifo idle");
    rx_serial <= 1'h0;
    repeat (60) @(posedge sys_clk);
    arst_n <= 1'h0;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'h1;
    rx_serial <= 1'h1;
    repeat (3) @(posedge sys_clk);
    chk("mode reset", 32'h0, 32'(fifo_enable));
    rdc(ls_a, 32'hff, 32'h60, "ls reset again");
    results();
  end
endmodule
`default_nettype wire
